//--- logic/gain_pkg.sv
package gain_pkg;

  // ********************************************************
  // Clock and timing
  // ********************************************************
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned ATTACK_TIME_US  = 6400;
  localparam int unsigned RELEASE_TIME_MS = 1810;
  localparam int unsigned HOLD_TIME_US    = 6400;
  localparam int unsigned ATTACK_CYCLES   = ATTACK_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned RELEASE_CYCLES  = RELEASE_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_CYCLES     = HOLD_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned TIMER_WIDTH     = 26;

  // ********************************************************
  // Gain in half-decibel steps
  // ********************************************************
  localparam int unsigned GAIN_WIDTH      = 7;
  localparam logic [6:0]  GAIN_FIXED      = 7'h0C;
  localparam logic [6:0]  GAIN_MAX        = 7'h3C;
  localparam logic [6:0]  GAIN_INCREMENT  = 7'h01;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [7:0]  CONTROL_OFFSET  = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
  localparam int unsigned FREEZE_BIT      = 0;
  localparam int unsigned STAT_GAIN_LSB   = 0;
  localparam int unsigned STAT_MODE_LSB   = 8;
  localparam int unsigned STAT_LEVEL_LSB  = 10;
  localparam int unsigned STAT_TIMER_LSB  = 13;
  localparam logic        CONTROL_RESET   = 1'b0;

  // ********************************************************
  // Input synchroniser slots and timer slots
  // ********************************************************
  localparam int unsigned PIN_COUNT       = 5;
  localparam int unsigned PIN_SEL_A       = 0;
  localparam int unsigned PIN_SEL_B       = 1;
  localparam int unsigned PIN_ABOVE       = 2;
  localparam int unsigned PIN_BELOW       = 3;
  localparam int unsigned PIN_QUIET       = 4;
  localparam int unsigned TIMER_COUNT     = 3;
  localparam int unsigned TMR_ATTACK      = 0;
  localparam int unsigned TMR_RELEASE     = 1;
  localparam int unsigned TMR_HOLD        = 2;

  typedef enum logic [1:0] {
    MODE_OFF      = 2'b00,
    MODE_LIMIT    = 2'b01,
    MODE_COMPRESS = 2'b10,
    MODE_GATE     = 2'b11
  } mode_type;

  typedef enum logic [1:0] {
    ST_DISABLED = 2'b00,
    ST_RUNNING  = 2'b01
  } state_type;

endpackage : gain_pkg

//--- logic/step_timer.sv
`timescale 1ns/100ps
module step_timer
  import gain_pkg::*;
#(
  parameter int unsigned WIDTH = TIMER_WIDTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] loadValue,
  output logic                  done
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             done_q;
  logic             done_d;

  // Counts down from the load value; done stays high once expired
  always_comb begin
    count_d = count_q;
    done_d  = done_q;
    if (restart) begin
      count_d = loadValue;
      done_d  = 1'b0;
    end else if (!done_q) begin
      if (count_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        done_d = 1'b1;
      end else begin
        count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      done_q  <= 1'b1;
    end else begin
      count_q <= count_d;
      done_q  <= done_d;
    end
  end

  assign done = done_q;

endmodule : step_timer

//--- logic/audio_gain_control.sv
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
// Behaviour
// R01: Gain moves only in 0.5 dB increments, one increment per adjustment; the code sets gain straight to GAIN_FIXED when the mode goes off.
// R02: Gain holds while the envelope sits between the limiter and desired levels.
// R03: A first rise above the limiter level cuts gain at once and restarts all timers.
// R04: While the attack timer runs no further cut is made.
// R05: Each attack expiry with the envelope still above the limiter cuts one step and restarts timers.
// R06: Each release expiry with the envelope below the desired level adds one step and restarts timers.
// R07: The two select pins choose off, limiter, limiter plus compression, or all plus noise gate.
// R08: Defaults are 6.4 ms attack, 1.81 s release, 6 dB fixed and 30 dB maximum gain.
// R09: Gain stays between fixed and maximum gain; steps past either bound are ignored.
module audio_gain_control
  import gain_pkg::*;
#(
  parameter int unsigned ATTACK_LOAD  = ATTACK_CYCLES,
  parameter int unsigned RELEASE_LOAD = RELEASE_CYCLES,
  parameter int unsigned HOLD_LOAD    = HOLD_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  functionSelectA,
  input  wire logic                  functionSelectB,
  input  wire logic                  envelopeAboveLimit,
  input  wire logic                  envelopeBelowTarget,
  input  wire logic                  envelopeBelowGate,
  output logic [GAIN_WIDTH-1:0]      steppedGainStage,
  output logic                       gainStepUp,
  output logic                       gainStepDown,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic [31:0]                hrdata,
  output logic                       hreadyout,
  output logic                       hresp
);

  // ********************************************************
  // Pin synchronisers: three stages, change taken when 2 and 3 agree
  // ********************************************************
  logic [PIN_COUNT-1:0] pinRaw;
  logic [PIN_COUNT-1:0] pinS1_q;
  logic [PIN_COUNT-1:0] pinS2_q;
  logic [PIN_COUNT-1:0] pinS3_q;
  logic [PIN_COUNT-1:0] pinStable_q;
  logic [PIN_COUNT-1:0] pinStable_d;

  assign pinRaw = {envelopeBelowGate, envelopeBelowTarget, envelopeAboveLimit,
                   functionSelectB, functionSelectA};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      always_comb begin
        pinStable_d[gi] = (pinS2_q[gi] == pinS3_q[gi]) ? pinS3_q[gi] : pinStable_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinS1_q     <= '0;
      pinS2_q     <= '0;
      pinS3_q     <= '0;
      pinStable_q <= '0;
    end else begin
      pinS1_q     <= pinRaw;
      pinS2_q     <= pinS1_q;
      pinS3_q     <= pinS2_q;
      pinStable_q <= pinStable_d;
    end
  end

  // ********************************************************
  // Mode decode
  // ********************************************************
  mode_type mode;
  logic     gateOn;

  assign mode   = mode_type'({pinStable_q[PIN_SEL_A], pinStable_q[PIN_SEL_B]});  // see R07
  assign gateOn = (mode == MODE_GATE);                                           // see R07

  // ********************************************************
  // Attack, release and hold timers
  // ********************************************************
  logic [TIMER_COUNT-1:0]                 timerDone;
  logic [TIMER_COUNT-1:0]                 timerRestart;
  logic [TIMER_COUNT-1:0][TIMER_WIDTH-1:0] timerLoad;

  assign timerLoad[TMR_ATTACK]  = TIMER_WIDTH'(ATTACK_LOAD);   // see R08
  assign timerLoad[TMR_RELEASE] = TIMER_WIDTH'(RELEASE_LOAD);  // see R08
  assign timerLoad[TMR_HOLD]    = TIMER_WIDTH'(HOLD_LOAD);

  generate
    for (gi = 0; gi < TIMER_COUNT; gi++) begin : g_timer
      step_timer #(
        .WIDTH(TIMER_WIDTH)
      ) u_timer (
        .clk      (clk),
        .rst      (rst),
        .restart  (timerRestart[gi]),
        .loadValue(timerLoad[gi]),
        .done     (timerDone[gi])
      );
    end
  endgenerate

  // ********************************************************
  // Gain sequencer
  // ********************************************************
  state_type                 state_q;
  state_type                 state_d;
  logic [GAIN_WIDTH-1:0]     gain_q;
  logic [GAIN_WIDTH-1:0]     gain_d;
  logic                      up_q;
  logic                      up_d;
  logic                      down_q;
  logic                      down_d;
  logic                      freeze_q;
  logic                      above;
  logic                      below;
  logic                      quiet;
  logic                      wantDown;
  logic                      wantUp;

  assign above = pinStable_q[PIN_ABOVE];
  assign below = pinStable_q[PIN_BELOW] && !above;
  assign quiet = pinStable_q[PIN_QUIET];

  // Expired attack timer lets the first crossing cut at once
  assign wantDown = above && timerDone[TMR_ATTACK] && (gain_q > GAIN_FIXED);   // see R03, R04, R05, R09
  assign wantUp   = below && timerDone[TMR_RELEASE] && timerDone[TMR_HOLD]
                    && !(gateOn && quiet) && (gain_q < GAIN_MAX);              // see R06, R09

  always_comb begin
    state_d      = state_q;
    gain_d       = gain_q;
    up_d         = 1'b0;
    down_d       = 1'b0;
    timerRestart = '0;
    case (state_q)
      ST_DISABLED: begin
        gain_d       = GAIN_FIXED;                                             // see R08
        timerRestart = {TIMER_COUNT{1'b1}};
        if (mode != MODE_OFF) begin
          state_d = ST_RUNNING;
        end
      end
      ST_RUNNING: begin
        if (mode == MODE_OFF) begin
          state_d = ST_DISABLED;                                               // see R07
        end else if (freeze_q) begin
          gain_d = gain_q;
        end else if (wantDown) begin
          gain_d       = gain_q - GAIN_INCREMENT;                              // see R01, R03, R05
          down_d       = 1'b1;
          timerRestart = {TIMER_COUNT{1'b1}};                                  // see R03, R05
        end else if (wantUp) begin
          gain_d       = gain_q + GAIN_INCREMENT;                              // see R01, R06
          up_d         = 1'b1;
          timerRestart = {TIMER_COUNT{1'b1}};                                  // see R06
        end else if (above) begin
          timerRestart[TMR_RELEASE] = 1'b1;
          timerRestart[TMR_HOLD]    = 1'b1;
        end
        // Between the two levels nothing moves                                 see R02
      end
      default: begin
        state_d = ST_DISABLED;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_DISABLED;
      gain_q  <= GAIN_FIXED;
      up_q    <= 1'b0;
      down_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      gain_q  <= gain_d;
      up_q    <= up_d;
      down_q  <= down_d;
    end
  end

  assign steppedGainStage = gain_q;
  assign gainStepUp       = up_q;
  assign gainStepDown     = down_q;

  // ********************************************************
  // AHB-Lite slave, zero wait states
  // ********************************************************
  logic        wrPend_q;
  logic        wrPend_d;
  logic [7:0]  wrAddr_q;
  logic [7:0]  wrAddr_d;
  logic        freeze_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        take;

  function automatic logic [31:0] read_word(input logic [7:0] offset);
    logic [31:0] word;
    word = 32'h0000_0000;
    case (offset)
      CONTROL_OFFSET: word[FREEZE_BIT] = freeze_q;
      STATUS_OFFSET: begin
        word[STAT_GAIN_LSB +: GAIN_WIDTH] = gain_q;
        word[STAT_MODE_LSB +: 2]          = mode;
        word[STAT_LEVEL_LSB +: 3]         = {quiet, below, above};
        word[STAT_TIMER_LSB +: 3]         = timerDone;
      end
      default: word = 32'h0000_0000;
    endcase
    return word;
  endfunction : read_word

  assign take = hsel && htrans[1] && hready;

  always_comb begin
    wrPend_d = take && hwrite;
    wrAddr_d = take ? haddr[7:0] : wrAddr_q;
    rdata_d  = (take && !hwrite) ? read_word(haddr[7:0]) : 32'h0000_0000;
    freeze_d = freeze_q;
    if (wrPend_q && (wrAddr_q == CONTROL_OFFSET)) begin
      freeze_d = hwdata[FREEZE_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      rdata_q  <= 32'h0000_0000;
      freeze_q <= CONTROL_RESET;
    end else begin
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      rdata_q  <= rdata_d;
      freeze_q <= freeze_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule : audio_gain_control

//--- testbench/audio_gain_control_properties.sv
`timescale 1ns/100ps
module audio_gain_control_properties
  import gain_pkg::*;
#(
  parameter int unsigned ATTACK_LOAD  = ATTACK_CYCLES,
  parameter int unsigned RELEASE_LOAD = RELEASE_CYCLES
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  functionSelectA,
  input wire logic                  functionSelectB,
  input wire logic [GAIN_WIDTH-1:0] steppedGainStage,
  input wire logic                  gainStepUp,
  input wire logic                  gainStepDown
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  int unsigned sinceStep_q;
  int unsigned sinceStep_d;
  // ****
  // Cycles since the last step, saturating
  // ****
  always_comb begin
    sinceStep_d = sinceStep_q;
    if (gainStepUp || gainStepDown) begin
      sinceStep_d = 0;
    end else if (sinceStep_q < RELEASE_LOAD) begin
      sinceStep_d = sinceStep_q + 1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sinceStep_q <= RELEASE_LOAD;
    end else begin
      sinceStep_q <= sinceStep_d;
    end
  end
  chk_down_one: assert property (
    gainStepDown |-> steppedGainStage == $past(steppedGainStage) - 7'h01) else $error("bad cut");
  chk_up_one: assert property (
    gainStepUp |-> steppedGainStage == $past(steppedGainStage) + 7'h01) else $error("bad raise");
  chk_one_dir: assert property (!(gainStepUp && gainStepDown)) else $error("both pulses");
  chk_hold_flat: assert property ($changed(steppedGainStage) |->
    gainStepUp || gainStepDown || steppedGainStage == GAIN_FIXED) else $error("silent change");
  chk_attack_gap: assert property (
    gainStepDown |-> sinceStep_q >= ATTACK_LOAD) else $error("cut too soon");
  chk_no_recut: assert property (
    gainStepDown |=> !gainStepDown [*8]) else $error("cut in attack");
  chk_release_gap: assert property (
    gainStepUp |-> sinceStep_q >= RELEASE_LOAD) else $error("raise too soon");
  chk_gain_range: assert property (
    steppedGainStage >= GAIN_FIXED && steppedGainStage <= GAIN_MAX) else $error("gain range");
  chk_mode_off: assert property (
    (!functionSelectA && !functionSelectB) [*6] |=> steppedGainStage == GAIN_FIXED
    && !gainStepUp) else $error("off mode gain");
  cover property (gainStepDown);
  cover property (gainStepUp);
  cover property (steppedGainStage == GAIN_MAX);
endmodule : audio_gain_control_properties
bind audio_gain_control audio_gain_control_properties #(
  .ATTACK_LOAD (ATTACK_LOAD),
  .RELEASE_LOAD(RELEASE_LOAD)
) u_props (.clk(clk), .rst(rst), .functionSelectA(functionSelectA),
  .functionSelectB(functionSelectB), .steppedGainStage(steppedGainStage),
  .gainStepUp(gainStepUp), .gainStepDown(gainStepDown));

//--- testbench/envelope_source.sv
`timescale 1ns/100ps
module envelope_source (
  input  wire logic       clk,
  input  wire logic [1:0] level,
  input  wire logic [1:0] mode,
  output logic            functionSelectA,
  output logic            functionSelectB,
  output logic            envelopeAboveLimit,
  output logic            envelopeBelowTarget,
  output logic            envelopeBelowGate
);
  // ****
  // Level 0 steady, 1 loud, 2 soft, 3 silent
  // ****
  always @(posedge clk) begin
    {functionSelectA, functionSelectB} <= mode;
    envelopeAboveLimit  <= (level == 2'h1);
    envelopeBelowTarget <= level[1];
    envelopeBelowGate   <= (level == 2'h3);
  end
endmodule : envelope_source

//--- testbench/tb.sv
`timescale 1ns/100ps
module tb
  import gain_pkg::*;
;
  logic        clk, rst, hsel, hwrite, hready, aboveLim, belowTgt, belowGt, selA, selB;
  logic        stepUp, stepDown, hreadyout, hresp;
  logic [1:0]  level, mode, htrans;
  logic [2:0]  hsize;
  logic [6:0]  gain;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          nFail, samplesChecked, nUp, nDown;
  assign hready = hreadyout;
  always #25 clk = ~clk;
  // Counts every one-cycle step pulse in the cycle it stands
  always @(posedge clk) begin
    if (stepUp === 1'b1) begin
      nUp <= nUp + 1;
    end
    if (stepDown === 1'b1) begin
      nDown <= nDown + 1;
    end
  end
  envelope_source u_src (.clk(clk), .level(level), .mode(mode), .functionSelectA(selA),
    .functionSelectB(selB), .envelopeAboveLimit(aboveLim), .envelopeBelowTarget(belowTgt),
    .envelopeBelowGate(belowGt));
  audio_gain_control #(.ATTACK_LOAD(20), .RELEASE_LOAD(40), .HOLD_LOAD(10)) u_dut (
    .clk(clk), .rst(rst), .functionSelectA(selA), .functionSelectB(selB),
    .envelopeAboveLimit(aboveLim), .envelopeBelowTarget(belowTgt),
    .envelopeBelowGate(belowGt), .steppedGainStage(gain), .gainStepUp(stepUp),
    .gainStepDown(stepDown), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  task automatic summarize;
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
      nFail++;
    end
  endtask : check
  task automatic waitReady;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    if (n >= 16) begin
      nFail++;
      summarize();
    end
  endtask : waitReady
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    waitReady();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wdata;
    waitReady();
    rd = hrdata;
    check("hresp", 32'h0, 32'(hresp));
  endtask : ahb
  task automatic waitGain(input logic [6:0] exp, input int limit);
    int n;
    n = 0;
    while (gain !== exp && n < limit) begin
      @(posedge clk);
      n++;
    end
    check("gain", 32'(exp), 32'(gain));
    if (gain !== exp) begin
      summarize();
    end
  endtask : waitGain
  task automatic stay(input int cycles, input logic [6:0] exp);
    repeat (cycles) @(posedge clk);
    check("gain", 32'(exp), 32'(gain));
  endtask : stay
  initial begin
    {clk, rst, hsel, hwrite} = 4'h4;
    {level, mode, htrans} = 6'h00;
    {haddr, hwdata} = 64'h0;
    nFail = 0;
    samplesChecked = 0;
    hsize = 3'h2;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("gain", 32'(GAIN_FIXED), 32'(gain));
    ahb(1'b0, 32'(CONTROL_OFFSET), 32'h0);
    check("control", 32'h0, rd);
    ahb(1'b1, 32'h8, 32'hFFFFFFFF);
    ahb(1'b0, 32'h8, 32'h0);
    check("unmapped", 32'h0, rd);
    ahb(1'b1, 32'(STATUS_OFFSET), 32'h7F);
    ahb(1'b0, 32'(STATUS_OFFSET), 32'h0);
    check("status gain", 32'(GAIN_FIXED), 32'(rd[6:0]));
    ahb(1'b1, 32'(CONTROL_OFFSET), 32'h1);
    ahb(1'b0, 32'(CONTROL_OFFSET), 32'h0);
    check("control", 32'h1, rd);
    mode  <= 2'h1;
    level <= 2'h2;
    stay(200, GAIN_FIXED);
    ahb(1'b1, 32'(CONTROL_OFFSET), 32'h0);
    $display("test registers done");
    waitGain(GAIN_FIXED + 7'h01, 100);
    waitGain(GAIN_MAX, 4000);
    stay(200, GAIN_MAX);
    level <= 2'h1;
    waitGain(GAIN_MAX - 7'h01, 10);
    stay(16, GAIN_MAX - 7'h01);
    waitGain(GAIN_MAX - 7'h02, 10);
    level <= 2'h0;
    stay(300, GAIN_MAX - 7'h02);
    level <= 2'h1;
    waitGain(GAIN_FIXED, 2000);
    stay(100, GAIN_FIXED);
    $display("test limiter done");
    for (int m = 0; m < 4; m++) begin
      mode <= 2'(m);
      repeat (8) @(posedge clk);
      ahb(1'b0, 32'(STATUS_OFFSET), 32'h0);
      check("status mode", 32'(m), 32'(rd[9:8]));
    end
    level <= 2'h3;
    stay(200, GAIN_FIXED);
    ahb(1'b0, 32'(STATUS_OFFSET), 32'h0);
    check("status levels", 32'h3E, 32'(rd[15:10]));
    mode  <= 2'h2;
    waitGain(GAIN_FIXED + 7'h01, 100);
    mode <= 2'h0;
    waitGain(GAIN_FIXED, 20);
    check("raises", 32'(GAIN_MAX - GAIN_FIXED + 7'h01), 32'(nUp));
    check("cuts", 32'(GAIN_MAX - GAIN_FIXED), 32'(nDown));
    $display("test modes done");
    summarize();
  end
endmodule : tb
